// ---- rtl/smlb_log_builder.sv ----
// smlb_log_builder: builds the log directory, summary error log, self-test log
// and attribute threshold sectors, and serves them one byte per read request.
// assumes all request inputs come from logic on i_ref_clk; no synchronisers.
`timescale 1ns/100ps
module smlb_log_builder #(
    parameter int CYC_PER_MS = smlb_pkg::CYC_PER_MS
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_cmd_valid,
    input wire smlb_pkg::smlb_cmd_t i_cmd,
    input wire logic i_err_req,
    input wire smlb_pkg::smlb_err_t i_err,
    output logic o_err_ready,
    input wire logic i_st_req,
    input wire smlb_pkg::smlb_st_t i_st,
    output logic o_st_ready,
    input wire logic [15:0] i_power_on_hours,
    input wire logic i_rd_req,
    input wire smlb_pkg::smlb_rd_t i_rd,
    output logic o_rd_ready,
    output logic o_rd_valid,
    output logic [7:0] o_rd_data,
    output logic o_rd_err
);
    typedef enum logic [1:0] {SMLB_IDLE, SMLB_ERR_WR, SMLB_ST_WR} smlb_state_t;

    function automatic logic [7:0] dir_byte(input logic [8:0] a);
        logic [7:0] log_a;
        log_a = a[8:1];
        if (a == 9'h000) begin
            dir_byte = smlb_pkg::DIR_VERSION;
        end else if (a[0]) begin
            dir_byte = 8'h00;
        end else if (log_a == smlb_pkg::LOG_ERR || log_a == smlb_pkg::LOG_SELFTEST) begin
            dir_byte = smlb_pkg::ONE_SECTOR;
        end else if (log_a >= smlb_pkg::LOG_HOST_LO && log_a <= smlb_pkg::LOG_HOST_HI) begin
            dir_byte = smlb_pkg::HOST_SECTORS;
        end else begin
            dir_byte = 8'h00;
        end
    endfunction

    function automatic logic [7:0] thr_byte(input int a);
        int rel;
        rel = a - smlb_pkg::THR_BASE;
        thr_byte = 8'h00;
        if (a == 0) begin
            thr_byte = smlb_pkg::THR_REV[7:0];
        end else if (a == 1) begin
            thr_byte = smlb_pkg::THR_REV[15:8];
        end else if (rel >= 0 && rel < smlb_pkg::ATTR_NUM * smlb_pkg::THR_ENTRY_LEN) begin
            if (rel % smlb_pkg::THR_ENTRY_LEN == 0) begin
                thr_byte = smlb_pkg::ATTR_ID[rel / smlb_pkg::THR_ENTRY_LEN];
            end else if (rel % smlb_pkg::THR_ENTRY_LEN == 1) begin
                thr_byte = smlb_pkg::ATTR_THR[rel / smlb_pkg::THR_ENTRY_LEN];
            end
        end
    endfunction

    function automatic logic [7:0] img_csum(input logic th);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < smlb_pkg::SECTOR_BYTES - 1; i++) begin
            s = s + (th ? thr_byte(i) : dir_byte(9'(i)));
        end
        img_csum = 8'h00 - s;
    endfunction

    // byte k of the record sits in bits 8k+7..8k, so shifting out low first is LSB first
    function automatic logic [719:0] build_err(input smlb_pkg::smlb_snap_t [4:0] h,
                                               input smlb_pkg::smlb_err_t e,
                                               input logic [15:0] hrs);
        logic [719:0] r;
        r = '0;
        for (int j = 0; j < 5; j++) begin
            r[j*smlb_pkg::CMD_SNAP_BITS +: smlb_pkg::CMD_SNAP_BITS] = {h[j].ts_ms,
                h[j].regs.command, h[j].regs.dev_head, h[j].regs.cyl_hi, h[j].regs.cyl_lo,
                h[j].regs.sec_num, h[j].regs.sec_cnt, h[j].regs.features,
                h[j].regs.dev_ctrl};
        end
        r[smlb_pkg::ERR_SNAP_BIT +: 240] = {hrs, smlb_pkg::STATE_HI, {1'b0, e.dstate},
            {smlb_pkg::ERR_VEND_BITS{1'b0}}, e.status, e.dev_head, e.cyl_hi, e.cyl_lo,
            e.sec_num, e.sec_cnt, e.error, 8'h00};
        build_err = r;
    endfunction

    localparam logic [7:0] DIR_CSUM = img_csum(1'b0);
    localparam logic [7:0] THR_CSUM = img_csum(1'b1);
    smlb_state_t state_q;
    logic [8:0] wr_addr_q;
    logic [6:0] wr_left_q;
    logic [719:0] rec_q;
    logic [7:0] err_mem [0:smlb_pkg::SECTOR_BYTES-1];
    logic [7:0] st_mem [0:smlb_pkg::SECTOR_BYTES-1];
    logic [7:0] err_sum_q;
    logic [7:0] st_sum_q;
    logic [2:0] err_idx_q;
    logic [2:0] err_idx_d;
    logic [15:0] err_cnt_q;
    logic [4:0] st_idx_q;
    logic [4:0] st_idx_d;
    smlb_pkg::smlb_snap_t [4:0] hist_q;
    logic [31:0] pre_q;
    logic [31:0] ms_q;
    logic err_take;
    logic st_take;
    logic rd_take;
    logic [7:0] rd_byte_c;
    logic rd_err_c;
    logic [7:0] err_csum_c;
    logic [7:0] st_csum_c;
    assign o_err_ready = (state_q == SMLB_IDLE);
    assign o_st_ready = (state_q == SMLB_IDLE) && !i_err_req;
    // reads wait while a record is half written, so a sector is never seen torn
    assign o_rd_ready = (state_q == SMLB_IDLE);
    assign err_take = o_err_ready && i_err_req;
    assign st_take = o_st_ready && i_st_req;
    assign rd_take = o_rd_ready && i_rd_req;
    assign err_idx_d = (err_idx_q == smlb_pkg::ERR_REC_NUM) ? smlb_pkg::ERR_IDX_FIRST
                                                             : err_idx_q + 3'h1;
    assign st_idx_d = (st_idx_q == smlb_pkg::ST_SLOTS) ? 5'h01 : st_idx_q + 5'h01;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            pre_q <= '0;
            ms_q <= '0;
        end else if (pre_q == 32'(CYC_PER_MS - 1)) begin
            pre_q <= '0;
            ms_q <= ms_q + 32'h1;
        end else begin
            pre_q <= pre_q + 32'h1;
        end
    end

    // hist_q[4] is the newest command, the one that failed when an error follows
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            hist_q <= '0;
        end else if (i_cmd_valid) begin
            hist_q <= {{i_cmd, ms_q}, hist_q[4:1]};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            err_idx_q <= smlb_pkg::ERR_REC_NUM;
            err_cnt_q <= '0;
        end else if (err_take) begin
            err_idx_q <= err_idx_d;
            if (err_cnt_q != smlb_pkg::ERR_CNT_MAX) begin
                err_cnt_q <= err_cnt_q + 16'h1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            st_idx_q <= '0;
        end else if (st_take) begin
            st_idx_q <= st_idx_d;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            state_q <= SMLB_IDLE;
            wr_addr_q <= '0;
            wr_left_q <= '0;
            rec_q <= '0;
        end else begin
            case (state_q)
                SMLB_IDLE: begin
                    if (err_take) begin
                        state_q <= SMLB_ERR_WR;
                        wr_addr_q <= 9'(smlb_pkg::ERR_REC0 +
                            9'(9'(err_idx_d - 3'h1) * smlb_pkg::ERR_REC_LEN));
                        wr_left_q <= smlb_pkg::ERR_REC_LEN[6:0];
                        rec_q <= build_err(hist_q, i_err, i_power_on_hours);
                    end else if (st_take) begin
                        state_q <= SMLB_ST_WR;
                        wr_addr_q <= 9'(smlb_pkg::ST_DESC0 +
                            9'(9'(st_idx_d - 5'h01) * smlb_pkg::ST_DESC_LEN));
                        wr_left_q <= smlb_pkg::ST_DESC_LEN[6:0];
                        rec_q <= {528'h0, {smlb_pkg::ST_VEND_BITS{1'b0}}, i_st.fail_lba,
                            i_st.checkpoint, i_power_on_hours, i_st.exec_status,
                            i_st.test_num};
                    end
                end
                SMLB_ERR_WR, SMLB_ST_WR: begin
                    rec_q <= {8'h00, rec_q[719:8]};
                    wr_addr_q <= wr_addr_q + 9'h001;
                    wr_left_q <= wr_left_q - 7'h01;
                    if (wr_left_q == 7'h01) begin
                        state_q <= SMLB_IDLE;
                    end
                end
                default: begin
                    state_q <= SMLB_IDLE;
                end
            endcase
        end
    end

    // sums track the array incrementally, so the checksum is ready the cycle writing ends
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            for (int i = 0; i < smlb_pkg::SECTOR_BYTES; i++) begin
                err_mem[i] <= 8'h00;
                st_mem[i] <= 8'h00;
            end
            err_sum_q <= '0;
            st_sum_q <= '0;
        end else if (state_q == SMLB_ERR_WR) begin
            err_mem[wr_addr_q] <= rec_q[7:0];
            err_sum_q <= err_sum_q + rec_q[7:0] - err_mem[wr_addr_q];
        end else if (state_q == SMLB_ST_WR) begin
            st_mem[wr_addr_q] <= rec_q[7:0];
            st_sum_q <= st_sum_q + rec_q[7:0] - st_mem[wr_addr_q];
        end
    end

    assign err_csum_c = 8'h00 - (err_sum_q + smlb_pkg::ERR_VERSION + {5'h00, err_idx_q} +
                                 err_cnt_q[7:0] + err_cnt_q[15:8]);
    assign st_csum_c = 8'h00 - (st_sum_q + smlb_pkg::ST_REV[7:0] + smlb_pkg::ST_REV[15:8] +
                                {3'h0, st_idx_q});

    always_comb begin
        rd_byte_c = 8'h00;
        rd_err_c = 1'b0;
        if (i_rd.thresh) begin
            rd_byte_c = (i_rd.byte_idx == smlb_pkg::LAST_BYTE) ? THR_CSUM
                                                              : thr_byte(int'(i_rd.byte_idx));
        end else if (i_rd.log_addr >= smlb_pkg::LOG_HOST_LO &&
                     i_rd.log_addr <= smlb_pkg::LOG_HOST_HI) begin
            // sector field is four bits wide, so exactly sixteen sectors exist
            rd_byte_c = 8'h00;
        end else if (i_rd.sector != 4'h0) begin
            rd_err_c = 1'b1;
        end else begin
            case (i_rd.log_addr)
                smlb_pkg::LOG_DIR: begin
                    rd_byte_c = (i_rd.byte_idx == smlb_pkg::LAST_BYTE) ? DIR_CSUM
                                                                      : dir_byte(i_rd.byte_idx);
                end
                smlb_pkg::LOG_ERR: begin
                    if (i_rd.byte_idx == 9'h000) begin
                        rd_byte_c = smlb_pkg::ERR_VERSION;
                    end else if (i_rd.byte_idx == smlb_pkg::ERR_IDX_OFS) begin
                        rd_byte_c = {5'h00, err_idx_q};
                    end else if (i_rd.byte_idx == smlb_pkg::ERR_CNT_OFS) begin
                        rd_byte_c = err_cnt_q[7:0];
                    end else if (i_rd.byte_idx == smlb_pkg::ERR_CNT_OFS + 9'h001) begin
                        rd_byte_c = err_cnt_q[15:8];
                    end else if (i_rd.byte_idx == smlb_pkg::LAST_BYTE) begin
                        rd_byte_c = err_csum_c;
                    end else begin
                        rd_byte_c = err_mem[i_rd.byte_idx];
                    end
                end
                smlb_pkg::LOG_SELFTEST: begin
                    if (i_rd.byte_idx == 9'h000) begin
                        rd_byte_c = smlb_pkg::ST_REV[7:0];
                    end else if (i_rd.byte_idx == 9'h001) begin
                        rd_byte_c = smlb_pkg::ST_REV[15:8];
                    end else if (i_rd.byte_idx == smlb_pkg::ST_IDX_OFS) begin
                        rd_byte_c = {3'h0, st_idx_q};
                    end else if (i_rd.byte_idx == smlb_pkg::LAST_BYTE) begin
                        rd_byte_c = st_csum_c;
                    end else begin
                        rd_byte_c = st_mem[i_rd.byte_idx];
                    end
                end
                default: begin
                    rd_err_c = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
            o_rd_err <= 1'b0;
        end else begin
            o_rd_valid <= rd_take;
            if (rd_take) begin
                o_rd_data <= rd_err_c ? 8'h00 : rd_byte_c;
                o_rd_err <= rd_err_c;
            end
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_err_write;
        (state_q == SMLB_ERR_WR) [*8];
    endsequence
    // a 90-byte record keeps the engine busy for exactly 90 cycles
    sequence s_back_idle;
        ##82 (state_q == SMLB_ERR_WR) ##1 (state_q == SMLB_IDLE);
    endsequence
    property p_err_idx_range;
        err_idx_q >= 3'h1 && err_idx_q <= 3'h5;
    endproperty
    a_err_idx_range: assert property (p_err_idx_range) else $error("error index out of 1..5");
    property p_err_idx_wrap;
        err_take |=> (err_idx_q == (($past(err_idx_q) == 3'h5) ? 3'h1 : $past(err_idx_q) + 3'h1));
    endproperty
    a_err_idx_wrap: assert property (p_err_idx_wrap) else $error("error index did not advance");
    property p_err_cnt_sat;
        (err_cnt_q == 16'hFFFF) |=> (err_cnt_q == 16'hFFFF);
    endproperty
    a_err_cnt_sat: assert property (p_err_cnt_sat) else $error("error count wrapped");
    property p_err_cnt_inc;
        (err_take && err_cnt_q != 16'hFFFF) |=> (err_cnt_q == $past(err_cnt_q) + 16'h1);
    endproperty
    a_err_cnt_inc: assert property (p_err_cnt_inc) else $error("error not counted");
    property p_err_fill;
        err_take |=> s_err_write ##0 s_back_idle;
    endproperty
    a_err_fill: assert property (p_err_fill) else $error("record fill length wrong");
    property p_st_idx_range;
        st_idx_q <= 5'h15;
    endproperty
    a_st_idx_range: assert property (p_st_idx_range) else $error("self-test index above 21");
    property p_st_ring;
        (st_take && st_idx_q == 5'h15) |=> (st_idx_q == 5'h01);
    endproperty
    a_st_ring: assert property (p_st_ring) else $error("self-test ring did not wrap");
    property p_rd_answer;
        rd_take |=> o_rd_valid ##1 !o_rd_valid || $past(rd_take);
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer not one cycle later");
    property p_no_read_busy;
        (st_take |=> (!o_rd_ready) [*8] ##16 !o_rd_ready ##1 o_rd_ready) and
        (err_take |=> (!o_rd_ready) [*8] ##82 !o_rd_ready ##1 o_rd_ready);
    endproperty
    a_no_read_busy: assert property (p_no_read_busy) else $error("read open during update");
    property p_err_version;
        (rd_take && !i_rd.thresh && i_rd.log_addr == 8'h01 && i_rd.sector == 4'h0 &&
         i_rd.byte_idx == 9'h000) |=> (o_rd_data == 8'h01 && !o_rd_err);
    endproperty
    a_err_version: assert property (p_err_version) else $error("error log version not 01h");
endmodule

// ---- include/smlb_pkg.sv ----
// smlb_pkg: constants, layouts and carriers for the health-log image builder.
// assumes a single 50 MHz device clock shared by every user of these types.
package smlb_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int SECTOR_BYTES = 512;
    localparam logic [8:0] LAST_BYTE = 9'h1FF;

    localparam logic [7:0] LOG_DIR = 8'h00;
    localparam logic [7:0] LOG_ERR = 8'h01;
    localparam logic [7:0] LOG_SELFTEST = 8'h06;
    localparam logic [7:0] LOG_HOST_LO = 8'h80;
    localparam logic [7:0] LOG_HOST_HI = 8'h9F;
    localparam logic [7:0] HOST_SECTORS = 8'h10;
    localparam logic [7:0] ONE_SECTOR = 8'h01;

    localparam logic [7:0] DIR_VERSION = 8'h01;

    localparam logic [7:0] ERR_VERSION = 8'h01;
    localparam logic [8:0] ERR_IDX_OFS = 9'h001;
    localparam logic [8:0] ERR_REC0 = 9'h002;
    localparam logic [8:0] ERR_REC_LEN = 9'h05A;
    localparam logic [8:0] ERR_CNT_OFS = 9'h1C4;
    localparam logic [2:0] ERR_REC_NUM = 3'h5;
    localparam logic [2:0] ERR_IDX_FIRST = 3'h1;
    localparam logic [15:0] ERR_CNT_MAX = 16'hFFFF;
    localparam int CMD_SNAP_BITS = 96;
    localparam int ERR_SNAP_BIT = 8 * 8'h3C;
    localparam int ERR_VEND_BITS = 8 * 19;
    localparam logic [3:0] STATE_HI = 4'h0;

    localparam logic [15:0] ST_REV = 16'h0001;
    localparam logic [8:0] ST_DESC0 = 9'h002;
    localparam logic [8:0] ST_DESC_LEN = 9'h018;
    localparam logic [4:0] ST_SLOTS = 5'h15;
    localparam logic [8:0] ST_IDX_OFS = 9'h1FC;
    localparam int ST_VEND_BITS = 8 * 15;

    localparam logic [15:0] THR_REV = 16'h0010;
    localparam int ATTR_NUM = 20;
    localparam int THR_ENTRY_LEN = 12;
    localparam int THR_BASE = 2;
    // one identifier list gives the attribute ids of the threshold image
    localparam logic [7:0] ATTR_ID [0:ATTR_NUM-1] = '{
        8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B,
        8'h0C, 8'hC0, 8'hC1, 8'hC2, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hF1, 8'hF2};
    localparam logic [7:0] ATTR_THR [0:ATTR_NUM-1] = '{default: 8'h00};

    typedef enum logic [2:0] {
        SMLB_DS_UNKNOWN, SMLB_DS_SLEEP, SMLB_DS_STANDBY, SMLB_DS_ACTIVE, SMLB_DS_OFFLINE
    } smlb_dstate_t;

    typedef struct packed {
        logic [7:0] dev_ctrl;
        logic [7:0] features;
        logic [7:0] sec_cnt;
        logic [7:0] sec_num;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] dev_head;
        logic [7:0] command;
    } smlb_cmd_t;

    typedef struct packed {
        smlb_cmd_t regs;
        logic [31:0] ts_ms;
    } smlb_snap_t;

    typedef struct packed {
        logic [7:0] error;
        logic [7:0] sec_cnt;
        logic [7:0] sec_num;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] dev_head;
        logic [7:0] status;
        smlb_dstate_t dstate;
    } smlb_err_t;

    typedef struct packed {
        logic [7:0] test_num;
        logic [7:0] exec_status;
        logic [7:0] checkpoint;
        logic [31:0] fail_lba;
    } smlb_st_t;

    typedef struct packed {
        logic thresh;
        logic [7:0] log_addr;
        logic [3:0] sector;
        logic [8:0] byte_idx;
    } smlb_rd_t;
endpackage

// ---- test/smlb_host_model.sv ----
// smlb_host_model: host side that fetches log bytes from the builder, one per request.
// assumes the builder registers its answer on the edge that takes a read.
`timescale 1ns/100ps
module smlb_host_model (
    input wire logic i_ref_clk,
    input wire logic i_rd_ready,
    input wire logic i_rd_valid,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_err,
    output logic o_rd_req,
    output smlb_pkg::smlb_rd_t o_rd
);
    initial begin
        o_rd_req = 1'b0;
        o_rd = '0;
    end

    // request and address stand until an edge has seen ready high
    task automatic rd(input logic th, input logic [7:0] la, input logic [3:0] sc,
            input logic [8:0] bi, output logic [7:0] d, output logic e);
        @(negedge i_ref_clk);
        o_rd_req = 1'b1;
        o_rd = '{thresh: th, log_addr: la, sector: sc, byte_idx: bi};
        while (i_rd_ready !== 1'b1) @(negedge i_ref_clk);
        @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        o_rd_req = 1'b0;
        // a released address is not left looking like the last one
        o_rd = ~o_rd;
        d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hXX;
        e = (i_rd_valid === 1'b1) ? i_rd_err : 1'bX;
    endtask
endmodule

// ---- test/test_smlb_log_builder.sv ----
// test_smlb_log_builder: fills the error and self-test logs and reads every image back.
// assumes the host model below is the only reader; the ms divider is shortened to 5.
`timescale 1ns/100ps
module test_smlb_log_builder;
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_cmd_valid = 1'b0;
    smlb_pkg::smlb_cmd_t i_cmd = '0;
    logic i_err_req = 1'b0;
    smlb_pkg::smlb_err_t i_err = '0;
    logic i_st_req = 1'b0;
    smlb_pkg::smlb_st_t i_st = '0;
    logic [15:0] i_power_on_hours = 16'h0000;
    logic i_rd_req;
    smlb_pkg::smlb_rd_t i_rd;
    logic o_err_ready, o_st_ready, o_rd_ready, o_rd_valid, o_rd_err;
    logic [7:0] o_rd_data, d;
    logic e;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    int ts = 0;

    smlb_log_builder #(.CYC_PER_MS(5)) i_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
        .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_err_req(i_err_req), .i_err(i_err),
        .o_err_ready(o_err_ready), .i_st_req(i_st_req), .i_st(i_st), .o_st_ready(o_st_ready),
        .i_power_on_hours(i_power_on_hours), .i_rd_req(i_rd_req), .i_rd(i_rd),
        .o_rd_ready(o_rd_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
        .o_rd_err(o_rd_err));
    smlb_host_model i_host (.i_ref_clk(i_ref_clk), .i_rd_ready(o_rd_ready),
        .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data), .i_rd_err(o_rd_err),
        .o_rd_req(i_rd_req), .o_rd(i_rd));

    always #10 i_ref_clk = ~i_ref_clk;

    // the whole run needs about 6100 cycles
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] x);
        n_tests++;
        if (got !== x) begin
            errors++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, x);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic x);
        n_tests++;
        if (got !== x) begin
            errors++;
            $display("unexpected at %0t: error flag %b, wanted %b", $time, got, x);
        end
    endtask

    task automatic chk(input logic th, input logic [7:0] la, input logic [3:0] sc,
            input logic [8:0] bi, input logic [7:0] x, input logic xe);
        i_host.rd(th, la, sc, bi, d, e);
        cmp(d, x);
        cmp_flag(e, xe);
    endtask

    task automatic cb(input logic [7:0] la, input logic [8:0] bi, input logic [7:0] x);
        chk(1'b0, la, 4'h0, bi, x, 1'b0);
    endtask

    task automatic sum0(input logic th, input logic [7:0] la);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 512; i++) begin
            i_host.rd(th, la, 4'h0, 9'(i), d, e);
            s = s + d;
        end
        cmp(s, 8'h00);
    endtask

    // one command just before each error, so snapshot 4 holds it and snapshot 3 the one before
    task automatic log_err(input logic [7:0] k);
        @(negedge i_ref_clk);
        // five reset edges come first, then the stamp steps once per five cycles
        ts = (cycles - 5) / 5;
        i_cmd_valid = 1'b1;
        i_cmd = 64'h0011223344556677 ^ {8{k}};
        @(negedge i_ref_clk);
        i_cmd_valid = 1'b0;
        i_err_req = 1'b1;
        i_err = {56'h8899AABBCCDDEE ^ {7{k}}, 3'(k % 5)};
        i_power_on_hours = {8'h50, k};
        while (o_err_ready !== 1'b1) @(negedge i_ref_clk);
        @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_err_req = 1'b0;
    endtask

    task automatic log_st(input logic [7:0] k);
        @(negedge i_ref_clk);
        i_st_req = 1'b1;
        i_st = {k, k ^ 8'hF0, k ^ 8'h3C, 24'h123456, k};
        i_power_on_hours = {8'h70, k};
        while (o_st_ready !== 1'b1) @(negedge i_ref_clk);
        @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_st_req = 1'b0;
    endtask

    task automatic t_dir();
        cb(8'h00, 9'h000, 8'h01);
        cb(8'h00, 9'h001, 8'h00);
        cb(8'h00, 9'h002, 8'h01);
        cb(8'h00, 9'h00C, 8'h01);
        for (int a = 8'h80; a <= 8'h9F; a++) cb(8'h00, 9'(2 * a), 8'h10);
        cb(8'h00, 9'h13F, 8'h00);
        cb(8'h00, 9'h1FE, 8'h00);
        sum0(1'b0, 8'h00);
    endtask

    task automatic t_err();
        logic [8:0] b;
        logic [7:0] k;
        cb(8'h01, 9'h000, 8'h01);
        for (int c = 1; c <= 6; c++) begin
            k = 8'(c);
            log_err(k);
            b = 9'h002 + 9'((c - 1) % 5) * 9'h05A;
            cb(8'h01, 9'h001, 8'(((c - 1) % 5) + 1));
            cb(8'h01, 9'h1C4, k);
            cb(8'h01, 9'h1C5, 8'h00);
            cb(8'h01, b + 9'h03C, 8'h00);
            cb(8'h01, b + 9'h057, {4'h0, 4'(c % 5)});
            cb(8'h01, b + 9'h058, k);
            cb(8'h01, b + 9'h059, 8'h50);
            for (int j = 0; j < 8; j++) cb(8'h01, b + 9'h030 + 9'(j), 8'(17 * j) ^ k);
            for (int j = 0; j < 7; j++) cb(8'h01, b + 9'h03D + 9'(j), 8'(136 + 17 * j) ^ k);
            if (c > 1) cb(8'h01, b + 9'h024, k - 8'h01);
            cb(8'h01, b + 9'h038, 8'(ts));
            cb(8'h01, b + 9'h039, 8'(ts >> 8));
        end
        sum0(1'b0, 8'h01);
    endtask

    task automatic t_st();
        logic [8:0] b;
        logic [7:0] k;
        cb(8'h06, 9'h1FC, 8'h00);
        for (int c = 1; c <= 22; c++) begin
            k = 8'(c);
            log_st(k);
            b = 9'h002 + 9'((c - 1) % 21) * 9'h018;
            cb(8'h06, 9'h1FC, 8'(((c - 1) % 21) + 1));
            cb(8'h06, b, k);
            cb(8'h06, b + 9'h001, k ^ 8'hF0);
            cb(8'h06, b + 9'h002, k);
            cb(8'h06, b + 9'h003, 8'h70);
            cb(8'h06, b + 9'h004, k ^ 8'h3C);
            cb(8'h06, b + 9'h005, k);
            cb(8'h06, b + 9'h008, 8'h12);
        end
        cb(8'h06, 9'h01A, 8'h02);
        sum0(1'b0, 8'h06);
    endtask

    task automatic t_thr();
        chk(1'b1, 8'h00, 4'h0, 9'h000, 8'h10, 1'b0);
        for (int k = 0; k < smlb_pkg::ATTR_NUM; k++) begin
            chk(1'b1, 8'h00, 4'h0, 9'(2 + 12 * k), smlb_pkg::ATTR_ID[k], 1'b0);
            chk(1'b1, 8'h00, 4'h0, 9'(3 + 12 * k), smlb_pkg::ATTR_THR[k], 1'b0);
        end
        sum0(1'b1, 8'h00);
    endtask

    task automatic t_bad();
        chk(1'b0, 8'h9F, 4'hF, 9'h1FF, 8'h00, 1'b0);
        chk(1'b0, 8'hA0, 4'h0, 9'h000, 8'h00, 1'b1);
        chk(1'b0, 8'h00, 4'h1, 9'h000, 8'h00, 1'b1);
    endtask

    initial begin
        repeat (5) @(negedge i_ref_clk);
        i_nrst = 1'b1;
        t_dir();
        t_err();
        t_st();
        t_thr();
        t_bad();
        conclude();
    end
endmodule
